// >>> hdl/sram_host_pkg.sv
// Constants shared by the static memory host controller
// What this block does
// - The host holds write data stable around the edge that ends the write.
// - The host never drives data while the memory may be driving it.
// - The host keeps the lane selects still while chip select is inactive.
// - The host holds the write strobe inactive throughout every read.
package sram_host_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 100;
  // Printed times in ns
  localparam int T_AA_NS = 55;
  localparam int T_HZOE_NS = 18;
  localparam int T_PWE_NS = 35;
  localparam int T_SD_NS = 25;
  localparam int T_AW_NS = 35;
  // Least times round up to whole cycles, never under one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int RD_CYC = cyc_min(T_AA_NS);
  localparam int TURN_CYC = cyc_min(T_HZOE_NS);
  localparam int WR_CYC = cyc_min((T_PWE_NS > T_SD_NS) ? T_PWE_NS : T_SD_NS);
  localparam int SETUP_CYC = cyc_min(0);
  localparam int CNT_W = 4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD = 3'b001,
    ST_TURN = 3'b010,
    ST_WSET = 3'b011,
    ST_WR = 3'b100,
    ST_WEND = 3'b101
  } state_t;
endpackage

// >>> hdl/sram_host.sv
// Host controller driving an asynchronous 128K x 16 static memory
`timescale 1ns/100ps
module sram_host
  import sram_host_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // User request
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [1:0] i_lane,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata,
  // Memory pins
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic o_chip_select_n,
  output logic o_write_strobe_n,
  output logic o_output_drive_n,
  output logic o_lower_lane_select_n,
  output logic o_upper_lane_select_n,
  output logic [DATA_W-1:0] o_mem_dq,
  output logic o_mem_dq_oe,
  input wire logic [DATA_W-1:0] i_mem_dq
);
  state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [1:0] lane_n_reg, lane_n_next;
  logic cs_n_reg, cs_n_next, we_n_reg, we_n_next, oe_n_reg, oe_n_next;
  logic dq_oe_reg, dq_oe_next, done_reg, done_next, busy_reg, busy_next;
  logic take, rd_last, turn_last, wset_last, wr_last, bad_state;

  // True on the last cycle of a step that lasts n cycles
  function automatic logic step_end(input logic [CNT_W-1:0] cnt, input int n);
    return cnt == CNT_W'(n - 1);
  endfunction

  // Step strobes, decoded once and shared by every group below
  always_comb begin
    // An empty lane mask would be a deselect, so such requests are dropped
    take = (state_reg == ST_IDLE) && i_req && (i_lane != 2'b00);
    // Read holds one cycle beyond the access time so data is well settled
    rd_last = (state_reg == ST_RD) && step_end(cnt_reg, RD_CYC + 1);
    turn_last = (state_reg == ST_TURN) && step_end(cnt_reg, TURN_CYC);
    wset_last = (state_reg == ST_WSET) && step_end(cnt_reg, SETUP_CYC);
    wr_last = (state_reg == ST_WR) && step_end(cnt_reg, WR_CYC);
    // Two of the eight codes are never entered on purpose
    bad_state = !(state_reg inside {ST_IDLE, ST_RD, ST_TURN, ST_WSET, ST_WR, ST_WEND});
  end

  // Sequencer: the step counter restarts at every change of state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 1'b1;
    unique case (state_reg)
      ST_IDLE: begin
        cnt_next = '0;
        if (take) begin
          state_next = i_we ? ST_WSET : ST_RD;
        end
      end
      ST_RD: begin
        if (rd_last) begin
          cnt_next = '0;
          state_next = ST_TURN;
        end
      end
      ST_TURN: begin
        // Wait out the memory's release of the data pins
        if (turn_last) begin
          cnt_next = '0;
          state_next = ST_IDLE;
        end
      end
      ST_WSET: begin
        if (wset_last) begin
          cnt_next = '0;
          state_next = ST_WR;
        end
      end
      ST_WR: begin
        if (wr_last) begin
          cnt_next = '0;
          state_next = ST_WEND;
        end
      end
      ST_WEND: begin
        cnt_next = '0;
        state_next = ST_IDLE;
      end
      default: begin
        cnt_next = '0;
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Memory pins; lane selects only move on the edge that selects the chip
  always_comb begin
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    lane_n_next = lane_n_reg;
    cs_n_next = cs_n_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    dq_oe_next = dq_oe_reg;
    if (take) begin
      addr_next = i_addr;
      wdata_next = i_wdata;
      lane_n_next = ~i_lane;
      cs_n_next = 1'b0;
      if (i_we) begin
        oe_n_next = 1'b1; // Memory never drives while we do
      end else begin
        we_n_next = 1'b1;
        oe_n_next = 1'b0;
      end
    end
    // Output drive and select rise together so the bus is free next cycle
    if (rd_last) begin
      oe_n_next = 1'b1;
      cs_n_next = 1'b1;
    end
    // Address settles before the strobe starts the write; data drive starts on the same edge as the strobe
    if (state_reg == ST_WSET) begin
      dq_oe_next = 1'b1;
    end
    if (wset_last) begin
      we_n_next = 1'b0;
    end
    if (wr_last) begin
      we_n_next = 1'b1; // Strobe edge ends the write
    end
    // Data held one cycle past the ending edge
    if (state_reg == ST_WEND) begin
      dq_oe_next = 1'b0;
      cs_n_next = 1'b1; // Output drive already high, so no read drive
    end
    // A corrupted state parks select, strobe, output drive and data enable at their idle levels
    if (bad_state) begin
      cs_n_next = 1'b1;
      we_n_next = 1'b1;
      oe_n_next = 1'b1;
      dq_oe_next = 1'b0;
    end
  end

  // Memory pin registers; selects come up inactive
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_reg <= '0;
      wdata_reg <= '0;
      lane_n_reg <= 2'b11;
      cs_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      dq_oe_reg <= 1'b0;
    end else begin
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      lane_n_reg <= lane_n_next;
      cs_n_reg <= cs_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      dq_oe_reg <= dq_oe_next;
    end
  end

  // User side: busy level, done pulse and captured read data
  always_comb begin
    rdata_next = rdata_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (take) begin
      busy_next = 1'b1;
    end
    if (rd_last) begin
      // Unselected byte floats at the memory; show zero
      rdata_next[7:0] = lane_n_reg[0] ? 8'h00 : i_mem_dq[7:0];
      rdata_next[15:8] = lane_n_reg[1] ? 8'h00 : i_mem_dq[15:8];
    end
    if (turn_last || (state_reg == ST_WEND)) begin
      done_next = 1'b1;
      busy_next = 1'b0;
    end
    // No done after a corrupted state, only a release of busy
    if (bad_state) begin
      busy_next = 1'b0;
    end
  end

  // User side registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= '0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
    end
  end

  // Outputs straight from flip-flops, no gate in between
  assign o_busy = busy_reg;
  assign o_done = done_reg;
  assign o_rdata = rdata_reg;
  assign o_mem_addr = addr_reg;
  assign o_chip_select_n = cs_n_reg;
  assign o_write_strobe_n = we_n_reg;
  assign o_output_drive_n = oe_n_reg;
  assign o_lower_lane_select_n = lane_n_reg[0];
  assign o_upper_lane_select_n = lane_n_reg[1];
  assign o_mem_dq = wdata_reg;
  assign o_mem_dq_oe = dq_oe_reg;
endmodule

// >>> test/sram_host_monitor.sv
// Assertions on the host controller's memory pins and handshake
`timescale 1ns/100ps
module sram_host_monitor
  import sram_host_pkg::*;
(
  // Clock, reset, request and handshake
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [1:0] i_lane,
  input wire logic o_busy,
  input wire logic o_done,
  // Memory pins
  input wire logic [DATA_W-1:0] o_mem_dq,
  input wire logic o_mem_dq_oe,
  input wire logic o_chip_select_n,
  input wire logic o_write_strobe_n,
  input wire logic o_output_drive_n,
  input wire logic o_lower_lane_select_n,
  input wire logic o_upper_lane_select_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  take_done_a: assert property (i_req && !o_busy && i_lane != 2'h0 |-> ##4 o_done)
    else $error("access did not finish in four cycles");
  rd_no_strobe_a: assert property (!o_output_drive_n |-> o_write_strobe_n)
    else $error("strobe low during read");
  no_fight_a: assert property (!o_output_drive_n || $past(!o_output_drive_n) |-> !o_mem_dq_oe)
    else $error("host drives data while memory may drive");
  lane_still_a: assert property (o_chip_select_n && $past(o_chip_select_n) |->
    $stable({o_lower_lane_select_n, o_upper_lane_select_n}))
    else $error("lane select moved while deselected");
  wr_hold_a: assert property ($rose(o_write_strobe_n) |-> o_mem_dq_oe && $stable(o_mem_dq))
    else $error("write data not held at strobe end");
  wr_qual_a: assert property (!o_write_strobe_n |-> !o_chip_select_n &&
    !(o_lower_lane_select_n && o_upper_lane_select_n))
    else $error("strobe without select or lane");
  wr_short_a: assert property ($fell(o_write_strobe_n) |=> $rose(o_write_strobe_n) ##1 o_chip_select_n)
    else $error("write not ended by strobe then select");
  done_idle_a: assert property (o_done |-> o_chip_select_n && o_output_drive_n && !o_mem_dq_oe)
    else $error("pins not idle at done");
  cover property ($fell(o_write_strobe_n));
  cover property ($fell(o_output_drive_n));
  cover property (o_done);
endmodule

bind sram_host sram_host_monitor sram_host_monitor_i (.*);

// >>> test/sram_model.sv
// Behavioural 128K x 16 static memory; ports named after the host pins they face
`timescale 1ns/100ps
module sram_model
  import sram_host_pkg::*;
(
  input wire logic i_clk,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic o_chip_select_n,
  input wire logic o_write_strobe_n,
  input wire logic o_output_drive_n,
  input wire logic o_lower_lane_select_n,
  input wire logic o_upper_lane_select_n,
  input wire logic [DATA_W-1:0] o_mem_dq,
  input wire logic o_mem_dq_oe,
  output logic [DATA_W-1:0] i_mem_dq
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic flt = 1'b0;
  logic rd;
  // Floating pins flip each cycle so a stale value never passes
  always @(posedge i_clk) flt <= ~flt;
  assign rd = !o_chip_select_n && o_write_strobe_n && !o_output_drive_n;
  assign i_mem_dq[7:0] = (rd && !o_lower_lane_select_n) ? mem[o_mem_addr][7:0] : {8{flt}};
  assign i_mem_dq[15:8] = (rd && !o_upper_lane_select_n) ? mem[o_mem_addr][15:8] : ~{8{flt}};
  // Level store while strobe, select and a lane overlap
  always @* if (!o_chip_select_n && !o_write_strobe_n) begin
    if (!o_lower_lane_select_n) mem[o_mem_addr][7:0] = o_mem_dq_oe ? o_mem_dq[7:0] : ~o_mem_dq[7:0];
    if (!o_upper_lane_select_n) mem[o_mem_addr][15:8] = o_mem_dq_oe ? o_mem_dq[15:8] : 8'h00;
  end
endmodule

// >>> test/test_sram_host.sv
// Bench for the static memory host controller
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_sram_host;
  import sram_host_pkg::*;
  logic i_clk = 0, i_rst = 1, i_req = 0, i_we = 0, o_busy, o_done, o_mem_dq_oe;
  logic o_chip_select_n, o_write_strobe_n, o_output_drive_n;
  logic o_lower_lane_select_n, o_upper_lane_select_n;
  logic [ADDR_W-1:0] i_addr = '0, o_mem_addr;
  logic [1:0] i_lane = '0;
  logic [DATA_W-1:0] i_wdata = '0, i_mem_dq, o_rdata, o_mem_dq, exp;
  int n_fail = 0, compares = 0, n;
  // Rows: write, address, lanes, write data, expected read data
  logic [51:0] rows [8] = '{{1'b1, 17'h0_0000, 2'h3, 16'h1234, 16'h0000},
    {1'b1, 17'h1_ffff, 2'h3, 16'habcd, 16'h0000}, {1'b1, 17'h1_ffff, 2'h1, 16'h0056, 16'h0000},
    {1'b1, 17'h1_ffff, 2'h2, 16'h7800, 16'h0000}, {1'b0, 17'h1_ffff, 2'h3, 16'h0000, 16'h7856},
    {1'b0, 17'h1_ffff, 2'h1, 16'h0000, 16'h0056}, {1'b0, 17'h1_ffff, 2'h2, 16'h0000, 16'h7800},
    {1'b0, 17'h0_0000, 2'h3, 16'h0000, 16'h1234}};
  sram_host sram_host_i (.*);
  sram_model sram_model_i (.*);
  always #50 i_clk = ~i_clk;
  // One access, counting cycles from the taking edge to done
  task op;
    @(negedge i_clk) i_req = 1;
    @(negedge i_clk) i_req = 0;
    n = 0;
    while (!o_done && n < 20) begin
      @(negedge i_clk);
      n++;
    end
  endtask
  task finish_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog: the whole run needs well under 200 cycles
  initial begin
    #20000 n_fail++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    @(negedge i_clk) i_rst = 0;
    `CHK({o_chip_select_n, o_mem_dq_oe, o_busy}, 3'b100)
    for (int k = 0; k < 9; k++) begin
      {i_we, i_addr, i_lane, i_wdata, exp} = rows[k % 8];
      op();
      `CHK(n, 3)
      if (!i_we) `CHK(o_rdata, exp)
      if (k == 7) begin
        // Empty lane request is refused, then a reset lands mid-read
        i_lane = 2'h0;
        @(negedge i_clk) i_req = 1;
        repeat (2) @(negedge i_clk);
        `CHK({o_busy, o_chip_select_n}, 2'b01)
        i_lane = 2'h3;
        repeat (2) @(negedge i_clk);
        i_req = 0;
        i_rst = 1;
        #1 `CHK({o_busy, o_chip_select_n, o_output_drive_n}, 3'b011)
        @(negedge i_clk) i_rst = 0;
      end
    end
    finish_test();
  end
endmodule
